// [logic/clkacc_top.sv]
// Purpose: Clock frequency accuracy unit: counts target edges between reference edges.
// Assumes: All clock sources are asynchronous pins slower than half of 40 MHz.
// Notes:   Register port answers reads one cycle later and never stalls.
//
// Contract
// - Main, sub, fast internal, slow internal, watchdog or peripheral clock B can be measured.
// - The target clock is picked by bits 3 to 1 of the target config register, codes 0 to 5.
// - The internal reference is picked by bits 3 to 1 of the reference config, codes 0 to 5.
// - The external reference pin may be chosen as reference instead of an internal clock.
// - Module stop halts the unit and clearing it resumes operation.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module clkacc_top
  import clkacc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // Clock sources
  input wire logic main_clk_i,
  input wire logic sub_clk_i,
  input wire logic fast_internal_osc_i,
  input wire logic slow_internal_osc_i,
  input wire logic watchdog_osc_clk_i,
  input wire logic peripheral_clk_b_i,
  input wire logic ext_reference_in_i,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] measure_target_config_ff;
  logic [CFG_W-1:0] measure_reference_config_ff;
  logic [CFG_W-1:0] ctrl_ff;
  logic [NUM_EV-1:0] status_ff;
  logic [NUM_EV-1:0] mask_ff;
  logic [CNT_W-1:0] upper_ff;
  logic [CNT_W-1:0] lower_ff;
  logic [CNT_W-1:0] result_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic irq_ff;

  logic [2:0] target_clock_sel;
  logic [2:0] reference_clock_sel;
  logic use_pin;
  logic stop;
  logic active;
  logic [NUM_SRC-1:0] src;
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] nxt_status;
  logic [NUM_EV-1:0] nxt_mask;

  clkacc_state_t state_ff;
  logic [CNT_W-1:0] count_ff;

  clkacc_edge_if tgt_if ();
  clkacc_edge_if ref_if ();

  assign target_clock_sel = measure_target_config_ff[SEL_MSB:SEL_LSB];
  assign reference_clock_sel = measure_reference_config_ff[SEL_MSB:SEL_LSB];
  assign use_pin = measure_reference_config_ff[REF_PIN_BIT];
  assign stop = ctrl_ff[STOP_BIT];
  assign active = measure_target_config_ff[MEAS_EN_BIT] & ~stop;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      measure_target_config_ff <= RST_TARGET;
      measure_reference_config_ff <= RST_REFER;
      ctrl_ff <= RST_CTRL;
      mask_ff <= '0;
      upper_ff <= RST_UPPER;
      lower_ff <= RST_LOWER;
    end else if (wr_i) begin
      unique case (addr_i)
        OFS_TARGET: measure_target_config_ff <= wdata_i[CFG_W-1:0];
        OFS_REFER: measure_reference_config_ff <= wdata_i[CFG_W-1:0];
        OFS_CTRL: ctrl_ff <= wdata_i[CFG_W-1:0];
        OFS_MASK: mask_ff <= wdata_i[NUM_EV-1:0];
        OFS_UPPER: upper_ff <= wdata_i[CNT_W-1:0];
        OFS_LOWER: lower_ff <= wdata_i[CNT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock selection
  // ----------------------------------------------------------------
  // Muxing raw clocks ahead of the synchroniser keeps one detector per path,
  // at the price of a possible stray edge right after a select change.
  assign src = {peripheral_clk_b_i, watchdog_osc_clk_i, slow_internal_osc_i,
                fast_internal_osc_i, sub_clk_i, main_clk_i};

  assign tgt_if.raw = clkacc_pick(src, target_clock_sel);
  assign tgt_if.filt_en = 1'b0;
  assign ref_if.raw = use_pin ? ext_reference_in_i
                              : clkacc_pick(src, reference_clock_sel);
  assign ref_if.filt_en = use_pin & measure_reference_config_ff[FILT_EN_BIT];

  clkacc_edge #(
    .FILT_LEN(FILT_CYC)
  ) u_tgt_edge (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .edge_if(tgt_if.det)
  );

  clkacc_edge #(
    .FILT_LEN(FILT_CYC)
  ) u_ref_edge (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .edge_if(ref_if.det)
  );

  // ----------------------------------------------------------------
  // Measurement
  // ----------------------------------------------------------------
  // A target edge in the same cycle as a reference edge is not counted.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= ST_IDLE;
      count_ff <= '0;
    end else if (!active) begin
      state_ff <= ST_IDLE;
      count_ff <= '0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          state_ff <= ST_ARM;
        end
        ST_ARM: begin
          if (ref_if.rise) begin
            state_ff <= ST_COUNT;
            count_ff <= '0;
          end
        end
        ST_COUNT: begin
          if (ref_if.rise) begin
            count_ff <= '0;
          end else if (tgt_if.rise) begin
            if (count_ff == CNT_MAX) begin
              state_ff <= ST_ARM;
              count_ff <= '0;
            end else begin
              count_ff <= count_ff + 16'h0001;
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    ev = '0;
    if (active && state_ff == ST_COUNT) begin
      ev[EV_END] = ref_if.rise;
      ev[EV_ERR] = ref_if.rise && (count_ff > upper_ff || count_ff < lower_ff);
      ev[EV_OVF] = !ref_if.rise && tgt_if.rise && count_ff == CNT_MAX;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_ff <= '0;
    end else if (ev[EV_END]) begin
      result_ff <= count_ff;
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------
  // A new event in the same cycle as its clear is kept.
  always_comb begin
    nxt_status = status_ff;
    if (wr_i && addr_i == OFS_STATUS) begin
      nxt_status = status_ff & ~wdata_i[NUM_EV-1:0];
    end
    nxt_status = nxt_status | ev;
  end

  // The level uses the mask as it will stand after this edge, so that a
  // mask write and the interrupt output change in the same cycle.
  always_comb begin
    nxt_mask = mask_ff;
    if (wr_i && addr_i == OFS_MASK) begin
      nxt_mask = wdata_i[NUM_EV-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff <= |(nxt_status & nxt_mask);
    end
  end

  assign irq_o = irq_ff;

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        OFS_TARGET: rdata_ff <= DATA_W'(measure_target_config_ff);
        OFS_REFER: rdata_ff <= DATA_W'(measure_reference_config_ff);
        OFS_CTRL: rdata_ff <= DATA_W'(ctrl_ff);
        OFS_STATUS: rdata_ff <= DATA_W'(status_ff);
        OFS_MASK: rdata_ff <= DATA_W'(mask_ff);
        OFS_UPPER: rdata_ff <= DATA_W'(upper_ff);
        OFS_LOWER: rdata_ff <= DATA_W'(lower_ff);
        OFS_RESULT: rdata_ff <= DATA_W'(result_ff);
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign rdata_o = rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_count_step;
    @(posedge clk_i) disable iff (!arst_n_i)
    (active && state_ff == ST_COUNT && tgt_if.rise && !ref_if.rise && count_ff != CNT_MAX)
      |=> count_ff == $past(count_ff) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("target edge not counted");

  property p_bad_target;
    @(posedge clk_i) disable iff (!arst_n_i)
    (target_clock_sel > CLK_PERIPHERAL_CLK_B) |-> !tgt_if.raw;
  endproperty
  a_bad_target: assert property (p_bad_target) else $error("bad code passes a clock");

  property p_ref_internal;
    @(posedge clk_i) disable iff (!arst_n_i)
    (!use_pin && reference_clock_sel == CLK_SLOW) |-> ref_if.raw == slow_internal_osc_i;
  endproperty
  a_ref_internal: assert property (p_ref_internal) else $error("wrong internal reference");

  property p_ref_pin;
    @(posedge clk_i) disable iff (!arst_n_i)
    use_pin |-> ref_if.raw == ext_reference_in_i &&
      ref_if.filt_en == measure_reference_config_ff[FILT_EN_BIT];
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("pin reference not routed");

  property p_stop_quiet;
    @(posedge clk_i) disable iff (!arst_n_i)
    stop |=> state_ff == ST_IDLE && count_ff == '0 && ev == '0;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("unit runs in module stop");

  property p_resume;
    @(posedge clk_i) disable iff (!arst_n_i)
    ($fell(stop) && measure_target_config_ff[MEAS_EN_BIT])
      |-> state_ff == ST_IDLE ##1 state_ff == ST_ARM;
  endproperty
  a_resume: assert property (p_resume) else $error("unit does not resume");

  property p_end_result;
    @(posedge clk_i) disable iff (!arst_n_i)
    ev[EV_END] |=> status_ff[EV_END] && result_ff == $past(count_ff);
  endproperty
  a_end_result: assert property (p_end_result) else $error("end event lost");

  property p_ovf;
    @(posedge clk_i) disable iff (!arst_n_i)
    ev[EV_OVF] |=> status_ff[EV_OVF] && state_ff == ST_ARM && count_ff == '0;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not handled");

  property p_irq;
    @(posedge clk_i) disable iff (!arst_n_i)
    ##1 irq_o == |(status_ff & mask_ff);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  c_end: cover property (@(posedge clk_i) disable iff (!arst_n_i) ev[EV_END]);
  c_err: cover property (@(posedge clk_i) disable iff (!arst_n_i) ev[EV_ERR]);
  c_ovf: cover property (@(posedge clk_i) disable iff (!arst_n_i) ev[EV_OVF]);
  c_pin: cover property (@(posedge clk_i) disable iff (!arst_n_i) use_pin && ev[EV_END]);

endmodule

`default_nettype wire

// [shared/clkacc_pkg.sv]
// Purpose: Constants, register map and clock codes of the clock accuracy unit.
// Assumes: One 40 MHz system clock; 32-bit register port with byte offsets.
// Notes:   Every offset and field position, and the reset values of the config, control and limit registers, live here.
`default_nettype none

package clkacc_pkg;

  // ----------------------------------------------------------------
  // Bus and timing
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CFG_W = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned FILT_TIME_NS = 100;
  // Least filter time, rounded up to whole cycles.
  localparam int unsigned FILT_CYC = (FILT_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_TARGET = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_REFER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_UPPER = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LOWER = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SEL_LSB = 1;
  localparam int unsigned SEL_MSB = 3;
  localparam int unsigned MEAS_EN_BIT = 0;
  localparam int unsigned REF_PIN_BIT = 0;
  localparam int unsigned FILT_EN_BIT = 4;
  localparam int unsigned STOP_BIT = 0;
  localparam int unsigned EV_END = 0;
  localparam int unsigned EV_ERR = 1;
  localparam int unsigned EV_OVF = 2;
  localparam int unsigned NUM_EV = 3;
  localparam logic [CFG_W-1:0] RST_TARGET = 8'h00;
  localparam logic [CFG_W-1:0] RST_REFER = 8'h00;
  localparam logic [CFG_W-1:0] RST_CTRL = 8'h01;
  localparam logic [CNT_W-1:0] RST_UPPER = 16'hffff;
  localparam logic [CNT_W-1:0] RST_LOWER = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

  // ----------------------------------------------------------------
  // Clock source codes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SRC = 6;
  localparam logic [2:0] CLK_MAIN = 3'h0;
  localparam logic [2:0] CLK_SUB = 3'h1;
  localparam logic [2:0] CLK_FAST = 3'h2;
  localparam logic [2:0] CLK_SLOW = 3'h3;
  localparam logic [2:0] CLK_WDOG = 3'h4;
  localparam logic [2:0] CLK_PERIPHERAL_CLK_B = 3'h5;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_COUNT
  } clkacc_state_t;

  // Picks one source; a prohibited code selects nothing so no edges appear.
  function automatic logic clkacc_pick(input logic [NUM_SRC-1:0] src, input logic [2:0] code);
    logic res;
    res = 1'b0;
    if (code <= CLK_PERIPHERAL_CLK_B) begin
      res = src[code];
    end
    return res;
  endfunction

endpackage

`default_nettype wire

// [shared/clkacc_edge_if.sv]
// Purpose: Carries one selected clock to its edge detector and the edge back.
// Assumes: The raw line is asynchronous to the system clock.
// Notes:   Driver end is the measurement core, detector end the edge module.
`timescale 1ns/1ps
`default_nettype none

interface clkacc_edge_if;
  logic raw;
  logic filt_en;
  logic rise;
  modport drv (output raw, output filt_en, input rise);
  modport det (input raw, input filt_en, output rise);
endinterface

`default_nettype wire

// [logic/clkacc_edge.sv]
// Purpose: Synchronises one clock line, optionally filters it, flags rising edges.
// Assumes: The line changes no faster than half the system clock rate.
// Notes:   Unfiltered, the rise pulse comes two to three cycles after the line rises.
`timescale 1ns/1ps
`default_nettype none

module clkacc_edge
  import clkacc_pkg::*;
#(
  parameter int unsigned FILT_LEN = FILT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Line and edge
  clkacc_edge_if.det edge_if
);

  logic sync1_ff;
  logic sync2_ff;
  logic cand_ff;
  logic [7:0] run_ff;
  logic level_ff;
  logic nxt_level;
  logic rise_ff;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= edge_if.raw;
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Noise filter
  // ----------------------------------------------------------------
  // A new level is taken only after it has stood for FILT_LEN samples.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cand_ff <= 1'b0;
      run_ff <= 8'h00;
    end else if (sync2_ff != cand_ff) begin
      cand_ff <= sync2_ff;
      run_ff <= 8'h00;
    end else if (run_ff < 8'(FILT_LEN - 1)) begin
      run_ff <= run_ff + 8'h01;
    end
  end

  always_comb begin
    nxt_level = sync2_ff;
    if (edge_if.filt_en) begin
      nxt_level = level_ff;
      if (sync2_ff == cand_ff && run_ff >= 8'(FILT_LEN - 1)) begin
        nxt_level = cand_ff;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      rise_ff <= nxt_level & ~level_ff;
    end
  end

  assign edge_if.rise = rise_ff;

endmodule

`default_nettype wire

// [testbench/tb.sv]
// Purpose: Self-checking bench for the clock accuracy unit through its register port.
// Assumes: Sources are divided from one free-running tick, so counts are known exactly.
// Notes:   A counted edge may coincide with a reference edge, so results allow one less.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import clkacc_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus signals
  // ----------------------------------------------------------------
  logic clk_i;
  logic arst_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic irq_o;
  logic [9:0] tick = '0;
  logic [5:0] src = '0;
  logic ext_ref = 1'b0;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [ADDR_W-1:0] ofs_tab [8] = '{OFS_TARGET, OFS_REFER, OFS_CTRL, OFS_STATUS,
    OFS_MASK, OFS_UPPER, OFS_LOWER, OFS_RESULT};
  logic [DATA_W-1:0] rst_tab [8] = '{{24'h0, RST_TARGET}, {24'h0, RST_REFER},
    {24'h0, RST_CTRL}, 32'h0, 32'h0, {16'h0, RST_UPPER}, {16'h0, RST_LOWER}, 32'h0};

  clkacc_top uut (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .main_clk_i(src[0]),
    .sub_clk_i(src[1]),
    .fast_internal_osc_i(src[2]),
    .slow_internal_osc_i(src[3]),
    .watchdog_osc_clk_i(src[4]),
    .peripheral_clk_b_i(src[5]),
    .ext_reference_in_i(ext_ref),
    .irq_o(irq_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Source k has a period of 4 << k cycles, the pin one of 512 cycles.
  always @(posedge clk_i) begin
    tick <= tick + 10'h001;
    for (int k = 0; k < 6; k++) begin
      src[k] <= tick[k+1];
    end
    ext_ref <= tick[8];
  end

  // ----------------------------------------------------------------
  // Timeout
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic check_value(input string name, input logic [DATA_W-1:0] exp,
                             input logic [DATA_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic check_range(input string name, input logic [DATA_W-1:0] lo,
                             input logic [DATA_W-1:0] hi, input logic [DATA_W-1:0] got);
    comparisons++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      failures++;
      $display("unexpected %s: expected %0d to %0d, seen %h", name, lo, hi, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    logic [DATA_W-1:0] d;
    check_value("irq after reset", 32'h0, {31'h0, irq_o});
    for (int i = 0; i < 8; i++) begin
      rd(ofs_tab[i], d);
      check_value("reset value", rst_tab[i], d);
    end
    wr(8'h20, 32'hffffffff);
    rd(8'h20, d);
    check_value("unmapped", 32'h0, d);
    wr(OFS_UPPER, 32'h00001234);
    rd(OFS_UPPER, d);
    check_value("upper limit", 32'h00001234, d);
    wr(OFS_UPPER, 32'h0000ffff);
  endtask

  // Module stop is set out of reset, so an enabled unit must stay silent.
  task automatic stop_holds();
    logic [DATA_W-1:0] d;
    wr(OFS_REFER, 32'h1);
    wr(OFS_TARGET, 32'h1);
    repeat (1200) @(posedge clk_i);
    rd(OFS_STATUS, d);
    check_value("status while stopped", 32'h0, d);
    rd(OFS_RESULT, d);
    check_value("result while stopped", 32'h0, d);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_CTRL, d);
    check_value("module stop", 32'h0, d);
  endtask

  task automatic measure(input logic [2:0] tc, input logic [7:0] rc, input int exp,
                         input logic err);
    logic [DATA_W-1:0] d;
    int n;
    wr(OFS_TARGET, {28'h0, tc, 1'b0});
    wr(OFS_STATUS, 32'h7);
    wr(OFS_REFER, {24'h0, rc});
    // A select change can leave one stray edge in the detector; let it drain while off.
    repeat (12) @(posedge clk_i);
    wr(OFS_TARGET, {28'h0, tc, 1'b1});
    rd(OFS_TARGET, d);
    check_value("target config", {28'h0, tc, 1'b1}, d & 32'hf);
    rd(OFS_REFER, d);
    check_value("reference config", {24'h0, rc}, d & 32'h1f);
    d = '0;
    n = 0;
    while (d[EV_END] !== 1'b1 && n < 600) begin
      rd(OFS_STATUS, d);
      n++;
    end
    check_value("end event", 32'h1, {31'h0, d[EV_END]});
    rd(OFS_RESULT, d);
    check_range("result", 32'(exp - 1), 32'(exp), d);
    rd(OFS_STATUS, d);
    check_value("error event", {31'h0, err}, {31'h0, d[EV_ERR]});
    wr(OFS_TARGET, {28'h0, tc, 1'b0});
  endtask

  // Raises a frequency error, then unmasks, masks, unmasks and clears it.
  task automatic error_irq();
    logic [DATA_W-1:0] d;
    wr(OFS_LOWER, 32'h000000c8);
    measure(CLK_MAIN, 8'h01, 128, 1'b1);
    wr(OFS_MASK, 32'h2);
    repeat (2) @(posedge clk_i);
    #1;
    check_value("irq unmasked", 32'h1, {31'h0, irq_o});
    wr(OFS_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    #1;
    check_value("irq masked", 32'h0, {31'h0, irq_o});
    wr(OFS_MASK, 32'h2);
    wr(OFS_STATUS, 32'h2);
    repeat (2) @(posedge clk_i);
    #1;
    check_value("irq cleared", 32'h0, {31'h0, irq_o});
    rd(OFS_STATUS, d);
    check_value("status after clear", 32'h1, d);
    wr(OFS_LOWER, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    reset_values();
    stop_holds();
    for (int c = 0; c < NUM_SRC; c++) begin
      measure(3'(c), 8'h01, 128 >> c, 1'b0);
    end
    for (int r = 0; r < NUM_SRC; r++) begin
      measure(CLK_MAIN, {4'h0, 3'(r), 1'b0}, 1 << r, 1'b0);
    end
    measure(CLK_SLOW, 8'h11, 16, 1'b0);
    error_irq();
    results();
  end
endmodule

`default_nettype wire
